// ### inc/cssr_cfg.svh
// register offsets, field positions, reset values and limits of the stop/restart unit
`ifndef CSSR_CFG_SVH
`define CSSR_CFG_SVH
`define CSSR_OFF_CTRL 12'h000
`define CSSR_OFF_INSTR 12'h004
`define CSSR_OFF_OPER 12'h008
`define CSSR_OFF_WORK 12'h00C
`define CSSR_OFF_AADDR 12'h010
`define CSSR_OFF_MASK 12'h014
`define CSSR_OFF_CMD 12'h018
`define CSSR_OFF_STATUS 12'h01C
`define CSSR_OFF_BK_INSTR 12'h020
`define CSSR_OFF_BK_OPER 12'h024
`define CSSR_OFF_BK_WORK 12'h028
`define CSSR_OFF_BK_AADDR 12'h02C
`define CSSR_OFF_OLD_PSW 12'h030
`define CSSR_OFF_MEMSIZE 12'h034
`define CSSR_CTRL_EMUL 0
`define CSSR_CTRL_OPTION 1
`define CSSR_CMD_CARD 0
`define CSSR_CMD_STACKER 1
`define CSSR_INTLK_BIT 0
`define CSSR_ADDR_LIMIT 16'h3E80
`define CSSR_MIN_STORAGE 32'h0000_4000
`define CSSR_CAUSE_STACKER 8'h71
`define CSSR_CAUSE_RST 8'h00
`define CSSR_MASK_RST 16'h0000
`define CSSR_MEMSIZE_RST 32'h0000_0000
`define CSSR_AREA_LOCAL 2'h0
`define CSSR_AREA_AUX1 2'h1
`define CSSR_AREA_AUX2 2'h2
`define CSSR_AREA_AUX3 2'h3
`endif

// ### inc/cssr_pkg.sv
// types shared by the stop/restart and mode-switch unit
package cssr_pkg;
  typedef enum logic [3:0] {
    CSSR_RUN,
    CSSR_SAVE,
    CSSR_CONVERT,
    CSSR_STORE_CAUSE,
    CSSR_HALTED,
    CSSR_RESTORE,
    CSSR_RESUME,
    CSSR_SW_SAVE,
    CSSR_SW_CALL
  } cssr_state_t;
  typedef logic [15:0] cssr_addr_t;
endpackage : cssr_pkg

// ### logic/cssr_ctrl.sv
// stop, restart and programmed mode-switch control for emulation mode
//
// Design decisions made here: the APB slave port and the register addresses.
`include "cssr_cfg.svh"
module cssr_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_req,
  input wire logic [7:0] stop_cause,
  input wire logic [3:0] stop_class,
  input wire logic stop_io_intv,
  input wire logic [7:0] stop_io_entry,
  input wire logic start_key,
  input wire logic mp_ref_valid,
  input wire logic [1:0] mp_ref_area,
  input wire logic mp_ref_true_local,
  output logic [15:0] addr_display_lights,
  output logic [15:0] ba_lights,
  output logic [7:0] result_lights,
  output logic halted,
  output logic resume_fetch,
  output logic resume_entry_valid,
  output logic [7:0] resume_entry,
  output logic [15:0] resume_addr,
  output logic svc_req,
  output logic [1:0] mem_area,
  output logic mem_blocked
);

  // thousands in binary, then hundreds, tens, units as decimal digits
  function automatic logic [15:0] cssr_to_display(input logic [15:0] a);
    logic [15:0] th;
    logic [15:0] rem;
    logic [15:0] hu;
    logic [15:0] te;
    logic [15:0] un;
    th = a / 16'h03E8;
    rem = a % 16'h03E8;
    hu = rem / 16'h0064;
    rem = rem % 16'h0064;
    te = rem / 16'h000A;
    un = rem % 16'h000A;
    if (a >= `CSSR_ADDR_LIMIT) begin
      cssr_to_display = a;
    end else begin
      cssr_to_display = {th[3:0], hu[3:0], te[3:0], un[3:0]};
    end
  endfunction : cssr_to_display

  cssr_pkg::cssr_state_t state_reg;
  logic emul_reg;
  logic option_reg;
  logic [31:0] memsize_reg;
  cssr_pkg::cssr_addr_t instr_addr_reg;
  cssr_pkg::cssr_addr_t operand_addr_reg;
  cssr_pkg::cssr_addr_t a_addr_reg;
  logic [23:0] work_reg;
  cssr_pkg::cssr_addr_t bk_instr_reg;
  cssr_pkg::cssr_addr_t bk_oper_reg;
  cssr_pkg::cssr_addr_t bk_aaddr_reg;
  logic [23:0] bk_work_reg;
  logic [7:0] switch_mask_hi;
  logic [7:0] switch_mask_lo;
  logic [7:0] cause_backup_byte;
  logic [7:0] restart_interlock_byte;
  logic [7:0] cause_reg;
  logic io_intv_reg;
  logic [7:0] io_entry_reg;
  logic [3:0] class_reg;
  logic [31:0] old_psw_reg;
  logic start_key_reg;
  logic option_active;
  logic start_press;
  logic wr_en;
  logic card_cmd;
  logic stacker_cmd;
  logic stacker_stop;
  logic any_stop;
  logic [7:0] any_cause;
  logic mask_hit;
  logic [15:0] mask_word;

  // option counts only on large enough storage
  assign option_active = option_reg && (memsize_reg >= `CSSR_MIN_STORAGE) && emul_reg;
  assign start_press = start_key && !start_key_reg;
  assign wr_en = psel && penable && pready && pwrite;
  assign card_cmd = wr_en && (paddr == `CSSR_OFF_CMD) && pwdata[`CSSR_CMD_CARD];
  assign stacker_cmd = wr_en && (paddr == `CSSR_OFF_CMD) && pwdata[`CSSR_CMD_STACKER];
  assign stacker_stop = stacker_cmd && restart_interlock_byte[`CSSR_INTLK_BIT];
  assign any_stop = emul_reg && (state_reg == cssr_pkg::CSSR_RUN) && (stop_req || stacker_stop);
  // cause byte passes through as row/column code, except a stacker stop, which loads CSSR_CAUSE_STACKER
  assign any_cause = stacker_stop ? `CSSR_CAUSE_STACKER : stop_cause;
  assign mask_word = {switch_mask_hi, switch_mask_lo};
  assign mask_hit = mask_word[stop_class];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_key_reg <= 1'b0;
    end else begin
      start_key_reg <= start_key;
    end
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cssr_pkg::CSSR_RUN;
    end else begin
      unique case (state_reg)
        cssr_pkg::CSSR_RUN: begin
          if (any_stop) begin
            if (option_active && mask_hit && !stacker_stop) begin
              state_reg <= cssr_pkg::CSSR_SW_SAVE;
            end else begin
              state_reg <= cssr_pkg::CSSR_SAVE;
            end
          end
        end
        cssr_pkg::CSSR_SAVE: state_reg <= cssr_pkg::CSSR_CONVERT;
        cssr_pkg::CSSR_CONVERT: state_reg <= cssr_pkg::CSSR_STORE_CAUSE;
        cssr_pkg::CSSR_STORE_CAUSE: state_reg <= cssr_pkg::CSSR_HALTED;
        cssr_pkg::CSSR_HALTED: begin
          if (start_press) begin
            state_reg <= cssr_pkg::CSSR_RESTORE;
          end
        end
        cssr_pkg::CSSR_RESTORE: state_reg <= cssr_pkg::CSSR_RESUME;
        cssr_pkg::CSSR_RESUME: state_reg <= cssr_pkg::CSSR_RUN;
        cssr_pkg::CSSR_SW_SAVE: state_reg <= cssr_pkg::CSSR_SW_CALL;
        cssr_pkg::CSSR_SW_CALL: state_reg <= cssr_pkg::CSSR_RUN;
        default: state_reg <= cssr_pkg::CSSR_RUN;
      endcase
    end
  end

  // latched stop details
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= `CSSR_CAUSE_RST;
      io_intv_reg <= 1'b0;
      io_entry_reg <= 8'h00;
      class_reg <= 4'h0;
    end else if (any_stop) begin
      cause_reg <= any_cause;
      io_intv_reg <= stop_io_intv && !stacker_stop;
      io_entry_reg <= stop_io_entry;
      class_reg <= stop_class;
    end
  end

  // control and mask registers; frozen while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emul_reg <= 1'b0;
      option_reg <= 1'b0;
      memsize_reg <= `CSSR_MEMSIZE_RST;
      switch_mask_hi <= 8'(`CSSR_MASK_RST >> 8);
      switch_mask_lo <= 8'(`CSSR_MASK_RST);
    end else if (wr_en && state_reg == cssr_pkg::CSSR_RUN) begin
      if (paddr == `CSSR_OFF_CTRL) begin
        emul_reg <= pwdata[`CSSR_CTRL_EMUL];
        option_reg <= pwdata[`CSSR_CTRL_OPTION];
      end
      if (paddr == `CSSR_OFF_MEMSIZE) begin
        memsize_reg <= pwdata;
      end
      if (paddr == `CSSR_OFF_MASK) begin
        switch_mask_hi <= pwdata[15:8];
        switch_mask_lo <= pwdata[7:0];
      end
    end
  end

  // emulated registers: software writes them while running, restart reloads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_addr_reg <= 16'h0000;
      operand_addr_reg <= 16'h0000;
      a_addr_reg <= 16'h0000;
      work_reg <= 24'h000000;
    end else if (state_reg == cssr_pkg::CSSR_RESTORE) begin
      instr_addr_reg <= bk_instr_reg;
      operand_addr_reg <= bk_oper_reg;
      a_addr_reg <= bk_aaddr_reg;
      work_reg <= bk_work_reg;
    end else if (wr_en && state_reg == cssr_pkg::CSSR_RUN && !any_stop) begin
      // a write racing a stop is dropped so the saved copy matches the lights
      if (paddr == `CSSR_OFF_INSTR) begin
        instr_addr_reg <= pwdata[15:0];
      end
      if (paddr == `CSSR_OFF_OPER) begin
        operand_addr_reg <= pwdata[15:0];
      end
      if (paddr == `CSSR_OFF_AADDR) begin
        a_addr_reg <= pwdata[15:0];
      end
      if (paddr == `CSSR_OFF_WORK) begin
        work_reg <= pwdata[23:0];
      end
    end
  end

  // backup locations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bk_instr_reg <= 16'h0000;
      bk_oper_reg <= 16'h0000;
      bk_aaddr_reg <= 16'h0000;
      bk_work_reg <= 24'h000000;
    end else if (state_reg == cssr_pkg::CSSR_SAVE) begin
      bk_instr_reg <= instr_addr_reg;
      bk_oper_reg <= operand_addr_reg;
      bk_aaddr_reg <= a_addr_reg;
      bk_work_reg <= work_reg;
    end else if (state_reg == cssr_pkg::CSSR_SW_SAVE) begin
      bk_instr_reg <= instr_addr_reg;
      bk_oper_reg <= operand_addr_reg;
      bk_aaddr_reg <= a_addr_reg;
    end
  end

  // console indicators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_display_lights <= 16'h0000;
      ba_lights <= 16'h0000;
      result_lights <= 8'h00;
    end else if (state_reg == cssr_pkg::CSSR_CONVERT) begin
      addr_display_lights <= cssr_to_display(instr_addr_reg);
      ba_lights <= cssr_to_display(operand_addr_reg);
      result_lights <= cause_reg;
    end
  end

  // first-auxiliary bytes: cause backup and restart interlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_backup_byte <= `CSSR_CAUSE_RST;
    end else if (state_reg == cssr_pkg::CSSR_STORE_CAUSE) begin
      cause_backup_byte <= result_lights;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_interlock_byte <= 8'h00;
    end else if (state_reg == cssr_pkg::CSSR_RESTORE) begin
      restart_interlock_byte[`CSSR_INTLK_BIT] <= 1'b1;
    end else if (card_cmd && state_reg == cssr_pkg::CSSR_RUN) begin
      restart_interlock_byte[`CSSR_INTLK_BIT] <= 1'b0;
    end
  end

  // resume and supervisor-call outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted <= 1'b0;
      resume_fetch <= 1'b0;
      resume_entry_valid <= 1'b0;
      resume_entry <= 8'h00;
      resume_addr <= 16'h0000;
      svc_req <= 1'b0;
      old_psw_reg <= 32'h0000_0000;
    end else begin
      halted <= (state_reg == cssr_pkg::CSSR_STORE_CAUSE) ||
                (state_reg == cssr_pkg::CSSR_HALTED && !start_press);
      resume_fetch <= 1'b0;
      resume_entry_valid <= 1'b0;
      svc_req <= 1'b0;
      if (state_reg == cssr_pkg::CSSR_RESUME) begin
        if (io_intv_reg) begin
          resume_entry_valid <= 1'b1;
          resume_entry <= io_entry_reg;
        end else begin
          resume_fetch <= 1'b1;
          resume_addr <= instr_addr_reg;
        end
      end
      if (state_reg == cssr_pkg::CSSR_SW_CALL) begin
        // class code with last instruction address
        old_psw_reg <= {bk_instr_reg, cause_reg, 4'h0, class_reg};
        svc_req <= 1'b1;
      end
    end
  end

  // storage area steering for microprogram references
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_area <= `CSSR_AREA_LOCAL;
      mem_blocked <= 1'b0;
    end else if (mp_ref_valid) begin
      mem_area <= mp_ref_area;
      mem_blocked <= 1'b0;
      if (option_active) begin
        // tables relocated, aux 1 references are blocked
        if (mp_ref_area == `CSSR_AREA_LOCAL && !mp_ref_true_local) begin
          // local references not flagged true-local go to aux 2
          mem_area <= `CSSR_AREA_AUX2;
        end
        if (mp_ref_area == `CSSR_AREA_AUX1) begin
          mem_blocked <= 1'b1;
        end
      end
    end
  end

  // apb slave: data captured in setup, answered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          `CSSR_OFF_CTRL: prdata <= {30'h0, option_reg, emul_reg};
          `CSSR_OFF_INSTR: prdata <= {16'h0000, instr_addr_reg};
          `CSSR_OFF_OPER: prdata <= {16'h0000, operand_addr_reg};
          `CSSR_OFF_WORK: prdata <= {8'h00, work_reg};
          `CSSR_OFF_AADDR: prdata <= {16'h0000, a_addr_reg};
          `CSSR_OFF_MASK: prdata <= {16'h0000, switch_mask_hi, switch_mask_lo};
          `CSSR_OFF_CMD: prdata <= 32'h0000_0000;
          `CSSR_OFF_STATUS: prdata <= {8'h00, restart_interlock_byte, cause_backup_byte,
                                       option_active, 3'h0, state_reg};
          `CSSR_OFF_BK_INSTR: prdata <= {16'h0000, bk_instr_reg};
          `CSSR_OFF_BK_OPER: prdata <= {16'h0000, bk_oper_reg};
          `CSSR_OFF_BK_WORK: prdata <= {8'h00, bk_work_reg};
          `CSSR_OFF_BK_AADDR: prdata <= {16'h0000, bk_aaddr_reg};
          `CSSR_OFF_OLD_PSW: prdata <= old_psw_reg;
          `CSSR_OFF_MEMSIZE: prdata <= memsize_reg;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule : cssr_ctrl

// ### dv/cssr_ctrl_checker.sv
// port assertions of the stop/restart and mode-switch unit
`include "cssr_cfg.svh"
module cssr_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_key,
  input wire logic mp_ref_valid,
  input wire logic mp_ref_true_local,
  input wire logic [15:0] addr_display_lights,
  input wire logic [15:0] ba_lights,
  input wire logic [7:0] result_lights,
  input wire logic halted,
  input wire logic resume_fetch,
  input wire logic resume_entry_valid,
  input wire logic svc_req,
  input wire logic [1:0] mem_area,
  input wire logic mem_blocked
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_halt_lights_stable: assert property (halted && $past(halted) |->
    $stable(addr_display_lights) && $stable(ba_lights) && $stable(result_lights))
    else $error("lights changed while halted");
  a_halt_until_start: assert property (halted && !$rose(start_key) |=> halted)
    else $error("halt left without start press");
  a_start_resumes: assert property ($rose(start_key) && halted |->
    ##[2:5] (resume_fetch || resume_entry_valid))
    else $error("no resume after start press");
  a_one_resume_kind: assert property (!(resume_fetch && resume_entry_valid))
    else $error("both resume kinds at once");
  a_svc_no_halt: assert property (svc_req |-> !halted ##1 !svc_req)
    else $error("supervisor call with halt or long pulse");
  a_true_local_ref: assert property (mp_ref_valid && mp_ref_true_local |=>
    mem_area == `CSSR_AREA_LOCAL && !mem_blocked)
    else $error("explicit local reference steered away");
  c_halt: cover property ($rose(halted));
  c_svc: cover property (svc_req);
  c_entry: cover property (resume_entry_valid);
  c_blocked: cover property (mem_blocked);
endmodule : cssr_ctrl_checker

bind cssr_ctrl cssr_ctrl_checker i_chk (.*);

// ### dv/cssr_console.sv
// operator console model: presses the start key some cycles after a halt
module cssr_console (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic halted,
  input wire logic [7:0] press_gap,
  output logic start_key
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 8'h00;
      start_key <= 1'b0;
    end else if (!halted) begin
      wait_reg <= 8'h00;
      start_key <= 1'b0;
    end else begin
      // saturate so a long halt never repeats the press
      if (wait_reg != 8'hFF) begin
        wait_reg <= wait_reg + 8'h01;
      end
      start_key <= (wait_reg >= press_gap) && (wait_reg < press_gap + 8'h03);
    end
  end
endmodule : cssr_console

// ### dv/cssr_ctrl_tb_top.sv
// self-checking bench for the stop/restart and mode-switch unit
`include "cssr_cfg.svh"
module cssr_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, stop_req, stop_io_intv, start_key, err, hit;
  logic mp_ref_valid, mp_ref_true_local, pready, pslverr, halted, resume_fetch;
  logic resume_entry_valid, svc_req, mem_blocked;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] stop_cause, stop_io_entry, result_lights, resume_entry, press_gap;
  logic [3:0] stop_class;
  logic [1:0] mp_ref_area, mem_area;
  logic [15:0] addr_display_lights, ba_lights, resume_addr;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  cssr_ctrl i_dut (.*);
  cssr_console i_con (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(q & m, e);
  endtask : chk
  task stop(input logic [7:0] c, input logic [3:0] k, input logic v, input logic [7:0] e);
    @(posedge pclk);
    stop_req <= 1'b1;
    stop_cause <= c;
    stop_class <= k;
    stop_io_intv <= v;
    stop_io_entry <= e;
    @(posedge pclk);
    stop_req <= 1'b0;
  endtask : stop
  task wait_halt(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (halted !== lvl && n < 20);
    check({31'h0, halted}, {31'h0, lvl});
  endtask : wait_halt
  task wait_res(input logic f);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((resume_fetch | resume_entry_valid) !== 1'b1 && n < 200);
    check({31'h0, resume_fetch}, {31'h0, f});
    check({31'h0, resume_entry_valid}, {31'h0, ~f});
  endtask : wait_res
  task mpref(input logic [1:0] a, input logic t, input logic [1:0] e, input logic b);
    @(posedge pclk);
    mp_ref_valid <= 1'b1;
    mp_ref_area <= a;
    mp_ref_true_local <= t;
    @(posedge pclk);
    mp_ref_valid <= 1'b0;
    @(posedge pclk);
    check({29'h0, mem_blocked, mem_area}, {29'h0, b, e});
  endtask : mpref
  initial begin
    {presetn, psel, penable, pwrite, stop_req, stop_io_intv} = 6'h00;
    {mp_ref_valid, mp_ref_true_local, mp_ref_area, stop_class} = 8'h00;
    {paddr, pwdata, stop_cause, stop_io_entry} = 60'h0;
    press_gap = 8'h28;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk(`CSSR_OFF_STATUS, 32'hFFFFFFFF, 32'h0);
    chk(`CSSR_OFF_MASK, 32'hFFFFFFFF, {16'h0, `CSSR_MASK_RST});
    chk(12'h100, 32'h0, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test reset done");
    apb(1'b1, `CSSR_OFF_CTRL, 32'h1);
    apb(1'b1, `CSSR_OFF_INSTR, 32'h04D2);
    apb(1'b1, `CSSR_OFF_OPER, 32'h3E7F);
    apb(1'b1, `CSSR_OFF_WORK, 32'h00ABCDEF);
    stop(8'h60, 4'h0, 1'b0, 8'h00);
    wait_halt(1'b1);
    check({16'h0, addr_display_lights}, 32'h1234);
    check({16'h0, ba_lights}, 32'hF999);
    check({24'h0, result_lights}, 32'h60);
    chk(`CSSR_OFF_STATUS, 32'h0000FF00, 32'h00006000);
    chk(`CSSR_OFF_BK_INSTR, 32'hFFFF, 32'h04D2);
    chk(`CSSR_OFF_BK_OPER, 32'hFFFF, 32'h3E7F);
    chk(`CSSR_OFF_BK_WORK, 32'hFFFFFF, 32'hABCDEF);
    apb(1'b1, `CSSR_OFF_INSTR, 32'h0);
    chk(`CSSR_OFF_INSTR, 32'hFFFF, 32'h04D2);
    wait_res(1'b1);
    check({16'h0, resume_addr}, 32'h04D2);
    chk(`CSSR_OFF_STATUS, 32'h00010000, 32'h00010000);
    $display("test halt and restart done");
    apb(1'b1, `CSSR_OFF_CMD, 32'h2);
    wait_halt(1'b1);
    check({24'h0, result_lights}, {24'h0, `CSSR_CAUSE_STACKER});
    wait_res(1'b1);
    apb(1'b1, `CSSR_OFF_CMD, 32'h1);
    chk(`CSSR_OFF_STATUS, 32'h00010000, 32'h0);
    apb(1'b1, `CSSR_OFF_CMD, 32'h2);
    repeat (6) @(posedge pclk);
    check({31'h0, halted}, 32'h0);
    $display("test interlock done");
    press_gap <= 8'h00;
    apb(1'b1, `CSSR_OFF_INSTR, 32'h3E80);
    stop(8'h41, 4'h0, 1'b1, 8'h5A);
    wait_halt(1'b1);
    check({16'h0, addr_display_lights}, 32'h3E80);
    wait_res(1'b0);
    check({24'h0, resume_entry}, 32'h5A);
    $display("test raw address and device entry done");
    apb(1'b1, `CSSR_OFF_MEMSIZE, 32'h4000);
    apb(1'b1, `CSSR_OFF_CTRL, 32'h3);
    apb(1'b1, `CSSR_OFF_MASK, 32'h8);
    apb(1'b1, `CSSR_OFF_INSTR, 32'h0100);
    apb(1'b1, `CSSR_OFF_AADDR, 32'h0ABC);
    stop(8'h04, 4'h3, 1'b0, 8'h00);
    hit = 1'b0;
    repeat (6) begin
      @(posedge pclk);
      hit = hit | (svc_req === 1'b1);
    end
    check({31'h0, hit}, 32'h1);
    check({31'h0, halted}, 32'h0);
    chk(`CSSR_OFF_OLD_PSW, 32'hFFFFFFFF, 32'h01000403);
    chk(`CSSR_OFF_BK_AADDR, 32'hFFFF, 32'h0ABC);
    chk(`CSSR_OFF_STATUS, 32'h80, 32'h80);
    mpref(`CSSR_AREA_LOCAL, 1'b0, `CSSR_AREA_AUX2, 1'b0);
    mpref(`CSSR_AREA_AUX1, 1'b0, `CSSR_AREA_AUX1, 1'b1);
    mpref(`CSSR_AREA_LOCAL, 1'b1, `CSSR_AREA_LOCAL, 1'b0);
    stop(8'h04, 4'h2, 1'b0, 8'h00);
    wait_halt(1'b1);
    wait_res(1'b1);
    apb(1'b1, `CSSR_OFF_MEMSIZE, 32'h3FFF);
    stop(8'h04, 4'h3, 1'b0, 8'h00);
    wait_halt(1'b1);
    chk(`CSSR_OFF_STATUS, 32'h80, 32'h0);
    wait_res(1'b1);
    $display("test mode switch done");
    final_report();
  end
endmodule : cssr_ctrl_tb_top
